/* File: verilog/eeprom_ctl.sv */
// Serial EEPROM access, autoload and AXI4-Lite control/status register
// Contract
// - A 0 to 1 write of start while not busy launches one cycle; command 0 reads, 1 writes
// - Hardware clears start when the requested EEPROM operation has ended
// - A write cycle sends the 16-bit data field to the EEPROM
// - A read cycle that ends with no missing acknowledge places the returned word in the data field
// - Read-only error flag sets on any missing acknowledge, else stays clear
// - Read-only complete flag sets only after a successful autoload
// - Serial clock divides core clock by 8192, 4096, 2048 or 256; default first
// - Autoload runs while the disable bit is 0, skipped when 1; resets to 0
// - Fast bit, reset to 1, makes autoload eight times faster
// - In-progress flag is 1 exactly while an autoload is underway
// - The seven-bit word address selects the location of software cycles
module eeprom_ctl #(
	parameter int unsigned DIV_0 = eeprom_ctl_pkg::DIV_RATIO_0,
	parameter int unsigned DIV_1 = eeprom_ctl_pkg::DIV_RATIO_1,
	parameter int unsigned DIV_2 = eeprom_ctl_pkg::DIV_RATIO_2,
	parameter int unsigned DIV_3 = eeprom_ctl_pkg::DIV_RATIO_3
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// EEPROM two-wire link
	output logic             scl_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	// Autoloaded configuration words
	output logic             cfg_we_o,
	output logic [6:0]       cfg_addr_o,
	output logic [15:0]      cfg_data_o
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [2:0] step_of(input logic wr,
		input logic [2:0] seq);
		logic [2:0] k;
		k = eeprom_ctl_pkg::K_STOP;
		if (seq == 3'h0) begin
			k = eeprom_ctl_pkg::K_START;
		end else if (seq <= 3'h2) begin
			k = eeprom_ctl_pkg::K_TX;
		end else if (wr) begin
			if (seq <= 3'h4) begin
				k = eeprom_ctl_pkg::K_TX;
			end
		end else begin
			case (seq)
				3'h3: k = eeprom_ctl_pkg::K_START;
				3'h4: k = eeprom_ctl_pkg::K_TX;
				3'h5: k = eeprom_ctl_pkg::K_RX_ACK;
				3'h6: k = eeprom_ctl_pkg::K_RX_NACK;
				default: k = eeprom_ctl_pkg::K_STOP;
			endcase
		end
		return k;
	endfunction

	function automatic logic [7:0] tx_of(input logic wr,
		input logic [2:0] seq, input logic [6:0] addr,
		input logic [15:0] data);
		logic [7:0] b;
		b = {eeprom_ctl_pkg::DEV_ADDR, 1'b0};
		case (seq)
			3'h2: b = {addr, 1'b0};
			3'h3: b = data[15:8];
			3'h4: b = wr ? data[7:0] : {eeprom_ctl_pkg::DEV_ADDR, 1'b1};
			default: b = {eeprom_ctl_pkg::DEV_ADDR, 1'b0};
		endcase
		return b;
	endfunction

	function automatic eeprom_ctl_pkg::eng_state_e state_of(
		input logic [2:0] k);
		eeprom_ctl_pkg::eng_state_e s;
		case (k)
			eeprom_ctl_pkg::K_START: s = eeprom_ctl_pkg::ST_START;
			eeprom_ctl_pkg::K_STOP:  s = eeprom_ctl_pkg::ST_STOP;
			default:                 s = eeprom_ctl_pkg::ST_BYTE;
		endcase
		return s;
	endfunction

	// Quarter of one serial bit, minus one, in core clock cycles
	function automatic logic [12:0] quarter_of(input logic [1:0] sel,
		input logic fast);
		int unsigned r;
		case (sel)
			2'h0: r = DIV_0;
			2'h1: r = DIV_1;
			2'h2: r = DIV_2;
			default: r = DIV_3;
		endcase
		r = r / eeprom_ctl_pkg::PHASES;
		if (fast) begin
			r = r / eeprom_ctl_pkg::FAST_FACTOR;
		end
		if (r == 0) begin
			r = 1;
		end
		return 13'(r - 1);
	endfunction

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic        aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic        awready_r, wready_r, arready_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r, rdata_r;
	logic [3:0]  w_strb_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        start_r, cmd_r, err_r, done_r, dis_r, fast_r;
	logic [1:0]  div_r;
	logic [6:0]  waddr_r;
	logic [15:0] data_r;
	logic        al_pend_r, al_busy_r;
	logic [6:0]  al_word_r;
	logic        cfg_we_r;
	logic [6:0]  cfg_addr_r;
	logic [15:0] cfg_data_r;
	eeprom_ctl_pkg::eng_state_e st_r;
	logic [2:0]  seq_r;
	logic [1:0]  ph_r;
	logic [3:0]  bit_r;
	logic [12:0] div_cnt_r;
	logic [7:0]  tx_sh_r;
	logic [15:0] rx_word_r, op_data_r;
	logic [6:0]  op_addr_r;
	logic        op_wr_r, op_al_r, nack_r;
	logic        scl_r, sda_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic        wr_do, wr_hit, wr_map, ar_fire, ar_map;
	logic        aw_fire, w_fire, busy, eng_idle, go, tick, fin;
	logic [31:0] reg_word, wmask, wval;
	logic [2:0]  cur_kind, nxt_kind;
	logic [7:0]  tx_next;
	logic        sw_start, al_first, scl_want, sda_want, al_fast;

	assign aw_fire  = s_axi_awvalid_i & awready_r;
	assign w_fire   = s_axi_wvalid_i & wready_r;
	assign wr_do    = aw_held_r & w_held_r & ~bvalid_r;
	assign wr_map   = aw_addr_r[7:2] == eeprom_ctl_pkg::CTL_OFS[7:2];
	assign wr_hit   = wr_do & wr_map;
	assign ar_fire  = s_axi_arvalid_i & arready_r;
	assign ar_map   = s_axi_araddr_i[7:2] == eeprom_ctl_pkg::CTL_OFS[7:2];
	assign reg_word = {data_r, waddr_r, al_busy_r, fast_r, dis_r, div_r,
		done_r, err_r, cmd_r, start_r};
	assign wmask    = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
		{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	assign wval     = (reg_word & ~wmask) | (w_data_r & wmask);

	assign eng_idle = st_r == eeprom_ctl_pkg::ST_IDLE;
	assign busy     = start_r | al_busy_r | ~eng_idle;
	assign sw_start = wr_hit & ~busy
		& wval[eeprom_ctl_pkg::START_BIT];
	assign al_first = al_pend_r & ~dis_r & ~busy;
	// Autoload words chain back to back while the in-progress flag holds
	assign go       = eng_idle & (al_busy_r | start_r);
	assign tick     = ~eng_idle & (div_cnt_r == 13'h0000);
	assign fin      = tick & (st_r == eeprom_ctl_pkg::ST_STOP)
		& (ph_r == 2'h3);
	// While idle the next access is known only from the autoload state;
	// the stored one still describes the access that just ended
	assign al_fast  = (eng_idle ? al_busy_r : op_al_r) & fast_r;
	assign cur_kind = step_of(op_wr_r, seq_r);
	assign nxt_kind = step_of(op_wr_r, seq_r + 3'h1);
	assign tx_next  = tx_of(op_wr_r, seq_r + 3'h1, op_addr_r, op_data_r);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else begin
			aw_held_r <= aw_held_r ? ~wr_do : aw_fire;
			w_held_r  <= w_held_r ? ~wr_do : w_fire;
			awready_r <= aw_held_r ? wr_do : ~aw_fire;
			wready_r  <= w_held_r ? wr_do : ~w_fire;
			if (aw_fire) begin
				aw_addr_r <= s_axi_awaddr_i;
			end
			if (w_fire) begin
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_r  <= 1'b0;
			bresp_r   <= eeprom_ctl_pkg::RESP_OKAY;
			rvalid_r  <= 1'b0;
			arready_r <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= eeprom_ctl_pkg::RESP_OKAY;
		end else begin
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_map ? eeprom_ctl_pkg::RESP_OKAY
					: eeprom_ctl_pkg::RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
			if (ar_fire) begin
				rvalid_r  <= 1'b1;
				arready_r <= 1'b0;
				rdata_r   <= ar_map ? reg_word : 32'h0000_0000;
				rresp_r   <= ar_map ? eeprom_ctl_pkg::RESP_OKAY
					: eeprom_ctl_pkg::RESP_SLVERR;
			end else if (rvalid_r) begin
				rvalid_r  <= ~s_axi_rready_i;
				arready_r <= s_axi_rready_i;
			end else begin
				arready_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control/status fields
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			start_r <= 1'b0;
			cmd_r   <= 1'b0;
			waddr_r <= eeprom_ctl_pkg::WADDR_RST;
			data_r  <= eeprom_ctl_pkg::DATA_RST;
			div_r   <= eeprom_ctl_pkg::DIV_RST;
			dis_r   <= eeprom_ctl_pkg::DIS_RST;
			fast_r  <= eeprom_ctl_pkg::FAST_RST;
		end else begin
			if (wr_hit) begin
				div_r  <= wval[eeprom_ctl_pkg::DIV_LSB +: 2];
				dis_r  <= wval[eeprom_ctl_pkg::DIS_BIT];
				fast_r <= wval[eeprom_ctl_pkg::FAST_BIT];
			end
			// Busy ignores the whole access part of the write
			if (wr_hit & ~busy) begin
				cmd_r   <= wval[eeprom_ctl_pkg::CMD_BIT];
				waddr_r <= wval[eeprom_ctl_pkg::WADDR_LSB +: 7];
				data_r  <= wval[eeprom_ctl_pkg::DATA_LSB +: 16];
			end
			if (sw_start) begin
				start_r <= 1'b1;
			end else if (fin & ~op_al_r) begin
				start_r <= 1'b0;
				if (~op_wr_r & ~nack_r) begin
					data_r <= rx_word_r;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Error, autoload sequencing and configuration output
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			err_r      <= 1'b0;
			done_r     <= 1'b0;
			al_pend_r  <= 1'b1;
			al_busy_r  <= 1'b0;
			al_word_r  <= 7'h00;
			cfg_we_r   <= 1'b0;
			cfg_addr_r <= 7'h00;
			cfg_data_r <= 16'h0000;
		end else begin
			cfg_we_r <= 1'b0;
			// Re-arm when software turns autoload back on
			if (wr_hit) begin
				al_pend_r <= (al_pend_r | dis_r)
					& ~wval[eeprom_ctl_pkg::DIS_BIT];
			end
			if (sw_start) begin
				err_r <= 1'b0;
			end else if (al_first) begin
				err_r     <= 1'b0;
				done_r    <= 1'b0;
				al_pend_r <= 1'b0;
				al_busy_r <= 1'b1;
				al_word_r <= 7'h00;
			end else if (fin) begin
				if (nack_r) begin
					err_r <= 1'b1;
				end
				if (op_al_r) begin
					// A failed word aborts, leaving complete clear
					al_busy_r <= ~nack_r & (al_word_r !=
						7'(eeprom_ctl_pkg::AL_WORDS - 1));
					done_r    <= ~nack_r & (al_word_r ==
						7'(eeprom_ctl_pkg::AL_WORDS - 1));
					al_word_r <= al_word_r + 7'h01;
					cfg_we_r   <= ~nack_r;
					cfg_addr_r <= al_word_r;
					cfg_data_r <= rx_word_r;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Bit clock divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_r <= 13'h0000;
		end else if (eng_idle | tick) begin
			div_cnt_r <= quarter_of(div_r, al_fast);
		end else begin
			div_cnt_r <= div_cnt_r - 13'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Two-wire engine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r      <= eeprom_ctl_pkg::ST_IDLE;
			seq_r     <= 3'h0;
			ph_r      <= 2'h0;
			bit_r     <= 4'h0;
			tx_sh_r   <= 8'h00;
			rx_word_r <= 16'h0000;
			op_wr_r   <= 1'b0;
			op_al_r   <= 1'b0;
			op_addr_r <= 7'h00;
			op_data_r <= 16'h0000;
			nack_r    <= 1'b0;
		end else if (go) begin
			st_r      <= eeprom_ctl_pkg::ST_START;
			seq_r     <= 3'h0;
			ph_r      <= 2'h0;
			nack_r    <= 1'b0;
			op_al_r   <= al_busy_r;
			op_wr_r   <= ~al_busy_r & cmd_r;
			op_addr_r <= al_busy_r ? al_word_r : waddr_r;
			op_data_r <= data_r;
		end else if (tick) begin
			ph_r <= ph_r + 2'h1;
			case (st_r)
				eeprom_ctl_pkg::ST_START: begin
					if (ph_r == 2'h3) begin
						seq_r   <= seq_r + 3'h1;
						st_r    <= state_of(nxt_kind);
						bit_r   <= 4'h0;
						tx_sh_r <= tx_next;
					end
				end
				eeprom_ctl_pkg::ST_BYTE: begin
					if (ph_r == 2'h2) begin
						if (bit_r == eeprom_ctl_pkg::ACK_BIT_IDX) begin
							if (cur_kind == eeprom_ctl_pkg::K_TX && sda_i) begin
								nack_r <= 1'b1;
							end
						end else if (cur_kind != eeprom_ctl_pkg::K_TX) begin
							rx_word_r <= {rx_word_r[14:0], sda_i};
						end
					end
					if (ph_r == 2'h3) begin
						if (bit_r != eeprom_ctl_pkg::ACK_BIT_IDX) begin
							bit_r   <= bit_r + 4'h1;
							tx_sh_r <= {tx_sh_r[6:0], 1'b0};
						end else if (nack_r) begin
							st_r <= eeprom_ctl_pkg::ST_STOP;
						end else begin
							seq_r   <= seq_r + 3'h1;
							st_r    <= state_of(nxt_kind);
							bit_r   <= 4'h0;
							tx_sh_r <= tx_next;
						end
					end
				end
				eeprom_ctl_pkg::ST_STOP: begin
					if (ph_r == 2'h3) begin
						st_r <= eeprom_ctl_pkg::ST_IDLE;
					end
				end
				default: st_r <= eeprom_ctl_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin levels: clock high in middle phases (phases 1 to 3 in stop), byte data moves while low
	// ----------------------------------------------------------------
	always_comb begin
		scl_want = 1'b1;
		sda_want = 1'b1;
		case (st_r)
			eeprom_ctl_pkg::ST_START: begin
				scl_want = (ph_r == 2'h1) | (ph_r == 2'h2);
				sda_want = ~ph_r[1];
			end
			eeprom_ctl_pkg::ST_BYTE: begin
				scl_want = (ph_r == 2'h1) | (ph_r == 2'h2);
				if (bit_r == eeprom_ctl_pkg::ACK_BIT_IDX) begin
					sda_want = cur_kind != eeprom_ctl_pkg::K_RX_ACK;
				end else if (cur_kind == eeprom_ctl_pkg::K_TX) begin
					sda_want = tx_sh_r[7];
				end
			end
			eeprom_ctl_pkg::ST_STOP: begin
				scl_want = ph_r != 2'h0;
				sda_want = ph_r[1];
			end
			default: begin
				scl_want = 1'b1;
				sda_want = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_r <= 1'b1;
			sda_r <= 1'b0;
		end else begin
			scl_r <= scl_want;
			// Kept as the pull-low enable so the pin leaves a flop
			sda_r <= ~sda_want;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = awready_r;
	assign s_axi_wready_o  = wready_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_arready_o = arready_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign s_axi_rdata_o   = rdata_r;
	assign s_axi_rresp_o   = rresp_r;
	assign scl_o           = scl_r;
	// Open drain: only ever pulls low
	assign sda_o           = 1'b0;
	assign sda_oe_o        = sda_r;
	assign cfg_we_o        = cfg_we_r;
	assign cfg_addr_o      = cfg_addr_r;
	assign cfg_data_o      = cfg_data_r;

endmodule

/* File: verilog/eeprom_ctl_pkg.sv */
// Constants shared by the serial EEPROM access and autoload block
package eeprom_ctl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned     ADDR_W       = 8;
	localparam logic [7:0]      CTL_OFS      = 8'h70;
	localparam logic [1:0]      RESP_OKAY    = 2'h0;
	localparam logic [1:0]      RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// Field positions in the control/status word
	// ----------------------------------------------------------------
	localparam int unsigned     START_BIT    = 0;
	localparam int unsigned     CMD_BIT      = 1;
	localparam int unsigned     ERR_BIT      = 2;
	localparam int unsigned     DONE_BIT     = 3;
	localparam int unsigned     DIV_LSB      = 4;
	localparam int unsigned     DIS_BIT      = 6;
	localparam int unsigned     FAST_BIT     = 7;
	localparam int unsigned     BUSY_BIT     = 8;
	localparam int unsigned     WADDR_LSB    = 9;
	localparam int unsigned     DATA_LSB     = 16;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]      DIV_RST      = 2'h0;
	localparam logic            DIS_RST      = 1'b0;
	localparam logic            FAST_RST     = 1'b1;
	localparam logic [6:0]      WADDR_RST    = 7'h00;
	localparam logic [15:0]     DATA_RST     = 16'h0000;

	// ----------------------------------------------------------------
	// Timing: divide ratios of the core clock, one serial bit per ratio
	// ----------------------------------------------------------------
	localparam int unsigned     DIV_RATIO_0  = 8192;
	localparam int unsigned     DIV_RATIO_1  = 4096;
	localparam int unsigned     DIV_RATIO_2  = 2048;
	localparam int unsigned     DIV_RATIO_3  = 256;
	localparam int unsigned     PHASES       = 4;
	localparam int unsigned     FAST_FACTOR  = 8;

	// ----------------------------------------------------------------
	// Two-wire framing
	// ----------------------------------------------------------------
	localparam logic [6:0]      DEV_ADDR     = 7'h50;
	localparam int unsigned     AL_WORDS     = 8;
	localparam logic [3:0]      ACK_BIT_IDX  = 4'h8;
	localparam logic [2:0]      K_START      = 3'h0;
	localparam logic [2:0]      K_TX         = 3'h1;
	localparam logic [2:0]      K_RX_ACK     = 3'h2;
	localparam logic [2:0]      K_RX_NACK    = 3'h3;
	localparam logic [2:0]      K_STOP       = 3'h4;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_START = 4'b0010,
		ST_BYTE  = 4'b0100,
		ST_STOP  = 4'b1000
	} eng_state_e;

endpackage

/* File: sim/eeprom_ctl_monitor.sv */
// Port-level assertions for the EEPROM control block
module eeprom_ctl_monitor (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	// Register bus
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// Link and autoload
	input wire logic        scl_o,
	input wire logic        cfg_we_o,
	input wire logic [6:0]  cfg_addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	logic [6:0] last_r;

	// Last autoloaded index, so the order can be followed across pulses
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_r <= 7'h7f;
		end else if (cfg_we_o) begin
			last_r <= cfg_addr_o;
		end
	end

	property p_scl_high;
		$rose(scl_o) |=> scl_o;
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("short high");
	property p_scl_low;
		$fell(scl_o) |=> !scl_o;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("short low");
	property p_cfg_pulse;
		cfg_we_o |=> !cfg_we_o;
	endproperty
	a_cfg_pulse: assert property (p_cfg_pulse) else $error("long pulse");
	property p_cfg_order;
		cfg_we_o |-> cfg_addr_o < 7'h08 &&
			(cfg_addr_o == 7'h00 || cfg_addr_o == last_r + 7'h01);
	endproperty
	a_cfg_order: assert property (p_cfg_order) else $error("bad order");
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=>
			s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=>
			s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
	property p_r_answer;
		s_axi_arvalid_i && s_axi_arready_o |=>
			s_axi_rvalid_o && !s_axi_arready_o;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("late read");
	property p_b_answer;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
			s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("late write");
	c_word: cover property (cfg_we_o && cfg_addr_o == 7'h07);
	c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
	c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule

/* File: sim/eeprom_model.sv */
// Behavioural two-wire serial EEPROM holding 16-bit words
module eeprom_model (
	// Two-wire link, line level after the pull-up
	input  wire logic scl_i,
	input  wire logic sda_i,
	// Withhold every acknowledge
	input  wire logic nack_i,
	output logic      pull_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [128];
	logic [15:0] rw;
	logic [7:0]  sh;
	logic [6:0]  ptr;
	logic        rd;
	int          bits;
	int          nbyte;

	initial begin
		pull_o = 1'b0;
		rd = 1'b0;
		for (int i = 0; i < 128; i++) mem[i] = 16'ha5c3 ^ 16'(i * 257);
	end
	// Start and stop are the only data moves while the clock is high
	always @(negedge sda_i) begin
		if (scl_i) begin
			bits = 0;
			nbyte = 0;
			rd = 1'b0;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i) pull_o = 1'b0;
	end
	always @(posedge scl_i) begin
		if (bits < 8) sh = {sh[6:0], sda_i};
		if (bits == 8 && rd && sda_i) rd = 1'b0;
		bits++;
	end
	// Line changes only while the clock is low
	always @(negedge scl_i) begin
		if (bits == 8 && !rd) begin
			if (nbyte == 0) rd = sh[0];
			if (nbyte == 1) ptr = sh[7:1];
			if (nbyte == 2) rw[15:8] = sh;
			if (nbyte == 3) mem[ptr] = {rw[15:8], sh};
			pull_o = !nack_i && (nbyte > 0 ||
				sh[7:1] == eeprom_ctl_pkg::DEV_ADDR);
		end else if (bits == 8) begin
			pull_o = 1'b0;
		end else if (bits >= 9) begin
			bits = 0;
			nbyte++;
			pull_o = 1'b0;
		end
		if (rd && bits < 8) begin
			if (bits == 0 && nbyte % 2 == 1) begin
				rw = mem[ptr];
				ptr++;
			end
			pull_o = !rw[15];
			rw = rw << 1;
		end
	end
endmodule

/* File: sim/eeprom_ctl_tb.sv */
// Self-checking bench for the EEPROM control block
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("Error at %0t: got %h, want %h", $time, g, e); \
	end \
end
module eeprom_ctl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Short divide ratios keep the run brief; fast autoload needs >= 32
	localparam int unsigned DV [4] = '{64, 32, 16, 8};
	localparam logic [7:0]  CTL = eeprom_ctl_pkg::CTL_OFS;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic        nack = 1'b0;
	logic [7:0]  aw = 8'h00, ar = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic        awr, wr, bv, arr, rv, scl, sdo, oe, pull, cfg_we;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [6:0]  cfg_a;
	logic [15:0] cfg_d;
	logic [31:0] seed = 32'h6256_b3a7;
	logic [15:0] ref_mem [128];
	logic [22:0] cfg_q [$];
	int          bad_count = 0;
	int          checks_done = 0;
	wire         sda = !((oe && !sdo) || pull);

	always #12.5 clk = !clk;
	eeprom_ctl #(.DIV_0(DV[0]), .DIV_1(DV[1]), .DIV_2(DV[2]), .DIV_3(DV[3]))
	i_dut (
		.clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr_i(aw),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
		.s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rry), .scl_o(scl), .sda_i(sda), .sda_o(sdo),
		.sda_oe_o(oe), .cfg_we_o(cfg_we), .cfg_addr_o(cfg_a),
		.cfg_data_o(cfg_d)
	);
	eeprom_model i_eep (.scl_i(scl), .sda_i(sda), .nack_i(nack), .pull_o(pull));
	always @(posedge clk) begin
		if (cfg_we === 1'b1) cfg_q.push_back({cfg_a, cfg_d});
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic finish_test();
		$display("Checks %0d, errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic time_out();
		bad_count++;
		$display("Error at %0t: no answer", $time);
		finish_test();
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv && n < 100);
		r = bresp;
		bry <= 1'b0;
		if (n >= 100) time_out();
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk);
		ar <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arr) arv <= 1'b0;
		end while (!rv && n < 100);
		d = rdata;
		r = rresp;
		rry <= 1'b0;
		if (n >= 100) time_out();
	endtask
	task automatic wait_idle(output logic [31:0] d);
		logic [1:0] r;
		int n;
		n = 0;
		do begin
			rd_reg(CTL, d, r);
			n++;
		end while ((d[0] || d[8]) && n < 20000);
		if (n >= 20000) time_out();
	endtask
	// Cycles from one rise of the serial clock to the next
	task automatic scl_period(output int p);
		repeat (2) begin
			p = 0;
			while (scl === 1'b1 && p < 9999) begin
				@(posedge clk);
				p++;
			end
			while (scl === 1'b0 && p < 9999) begin
				@(posedge clk);
				p++;
			end
		end
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [6:0]  a;
		logic [15:0] w;
		int          p;
		for (int i = 0; i < 128; i++) ref_mem[i] = 16'ha5c3 ^ 16'(i * 257);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		scl_period(p);
		`CHK(p, int'(DV[0] / 8))
		rd_reg(CTL, d, r);
		`CHK(d[8:4], 5'h18)
		wait_idle(d);
		`CHK(d[3:2], 2'b10)
		// Rerun at normal speed by toggling the disable bit
		wr_reg(CTL, 32'h0000_0040, r);
		wr_reg(CTL, 32'h0000_0000, r);
		scl_period(p);
		`CHK(p, int'(DV[0]))
		wait_idle(d);
		`CHK(cfg_q.size(), 16)
		foreach (cfg_q[i]) `CHK(cfg_q[i], {7'(i % 8), ref_mem[i % 8]})
		nack <= 1'b1;
		wr_reg(CTL, 32'h0000_0040, r);
		wr_reg(CTL, 32'h0000_0080, r);
		wait_idle(d);
		`CHK(d[3:2], 2'b01)
		nack <= 1'b0;
		// Write then read back at every divide; the second start is ignored
		for (int k = 0; k < 4; k++) begin
			a = 7'(rnd());
			w = 16'(rnd());
			wr_reg(CTL, {w, a, 3'b110, 2'(k), 4'hf}, r);
			wr_reg(CTL, {~w, ~a, 3'b110, 2'(k), 4'h3}, r);
			scl_period(p);
			`CHK(p, int'(DV[k]))
			wait_idle(d);
			`CHK(d[15:0], {a, 3'b010, 2'(k), 4'h2})
			`CHK(i_eep.mem[a], w)
			ref_mem[a] = w;
			wr_reg(CTL, {16'h0000, a, 3'b010, 2'(k), 4'h1}, r);
			wait_idle(d);
			`CHK(d[31:16], ref_mem[a])
			`CHK(d[2:0], 3'b000)
		end
		nack <= 1'b1;
		wr_reg(CTL, 32'h0000_0081, r);
		wait_idle(d);
		`CHK(d[2:0], 3'b100)
		nack <= 1'b0;
		wr_reg(8'h74, 32'hffff_ffff, r);
		`CHK(r, eeprom_ctl_pkg::RESP_SLVERR)
		rd_reg(8'h74, d, r);
		`CHK({r, d}, {eeprom_ctl_pkg::RESP_SLVERR, 32'h0000_0000})
		finish_test();
	end
endmodule
bind eeprom_ctl eeprom_ctl_monitor i_mon (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_o(scl_o),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o)
);
